// *** inc/sfs_pkg.sv ***
// Purpose: constants for the stack frame sequencer
// Assumes: 16-bit address, 8-bit data, one bus cycle per clock
// Notes:   offsets are relative to the stack pointer at start
package sfs_pkg;
	localparam logic [15:0] VEC_TRAP_ADDR = 16'hFFFA;
	localparam logic [15:0] SP_RST        = 16'h0000;
	localparam logic [3:0]  TRAP_CYCLES   = 4'hC;
	localparam logic [3:0]  RTI_CYCLES    = 4'hA;
	localparam logic [15:0] FRAME_SIZE    = 16'h0007;
	localparam int          CC_MASK_BIT   = 4;
	localparam int          CLK_HZ        = 10000000;

	typedef enum logic [1:0] {
		SFS_IDLE  = 2'b00,
		SFS_RTI   = 2'b01,
		SFS_TRAP  = 2'b10
	} sfs_mode_t;
endpackage

// *** src/sfs_step_rom.sv ***
// Purpose: per-step address offset and direction table
// Assumes: step numbers start at 1 as the first bus cycle
// Notes:   registered output, one cycle of latency
`timescale 1ns/1ps
`default_nettype none
module sfs_step_rom (
	input  wire logic        clk_sys_i,
	input  wire logic        rst_n_i,
	input  wire logic        trap_i,
	input  wire logic [3:0]  step_i,
	output logic      [15:0] off_o,
	output logic             wr_o
);
	logic [16:0] next_ent;
	logic [16:0] ent;

	// Offsets added to SP; sign folded into 16-bit wrap
	always_comb begin
		next_ent = {1'b0, 16'h0000};
		if (trap_i) begin
			case (step_i)
				4'h3: next_ent = {1'b1, 16'h0000};
				4'h4: next_ent = {1'b1, 16'hFFFF};
				4'h5: next_ent = {1'b1, 16'hFFFE};
				4'h6: next_ent = {1'b1, 16'hFFFD};
				4'h7: next_ent = {1'b1, 16'hFFFC};
				4'h8: next_ent = {1'b1, 16'hFFFB};
				4'h9: next_ent = {1'b1, 16'hFFFA};
				4'hA: next_ent = {1'b0, 16'hFFF9};
				default: next_ent = {1'b0, 16'h0000};
			endcase
		end else begin
			case (step_i)
				4'h3: next_ent = {1'b0, 16'h0000};
				4'h4: next_ent = {1'b0, 16'h0001};
				4'h5: next_ent = {1'b0, 16'h0002};
				4'h6: next_ent = {1'b0, 16'h0003};
				4'h7: next_ent = {1'b0, 16'h0004};
				4'h8: next_ent = {1'b0, 16'h0005};
				4'h9: next_ent = {1'b0, 16'h0006};
				4'hA: next_ent = {1'b0, 16'h0007};
				default: next_ent = {1'b0, 16'h0000};
			endcase
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ent <= 17'h00000;
		end else begin
			ent <= next_ent;
		end
	end

	assign off_o = ent[15:0];
	assign wr_o  = ent[16];
endmodule
`default_nettype wire

// *** src/sfs_top.sv ***
// Purpose: bus sequencer for frame restore and soft trap
// Assumes: memory answers reads in the same cycle on rdata
// Notes:   one bus cycle per clock, starts only when idle
`timescale 1ns/1ps
`default_nettype none
// Function
// [RL1] Restore reads condition codes from SP+1.
// [RL2] Restore reads accumulator B at SP+2, then A at SP+3.
// [RL3] Restore reads index high at SP+4, low at SP+5.
// [RL4] Restore reads return address high at SP+6, low at SP+7.
// [RL5] Trap: 12 cycles, opcode, dummy read, PC low at SP, high SP-1.
// [RL6] Trap writes index low at SP-2, high at SP-3.
// [RL7] Trap writes A at SP-4, B at SP-5, condition codes at SP-6.
// [RL8] Dummy read SP-7, then vector high at FFFA, low at FFFB.
// [RL9] After trap: set mask, drop SP by frame, jump to vector.
module sfs_top (
	input  wire logic        clk_sys_i,
	input  wire logic        rst_n_i,
	input  wire logic        start_rti_i,
	input  wire logic        start_trap_i,
	input  wire logic [15:0] pc_i,
	input  wire logic [15:0] sp_i,
	input  wire logic [15:0] ix_i,
	input  wire logic [7:0]  acc_a_i,
	input  wire logic [7:0]  acc_b_i,
	input  wire logic [7:0]  cc_i,
	input  wire logic [7:0]  rdata_i,
	output logic      [15:0] addr_o,
	output logic      [7:0]  wdata_o,
	output logic             rd_o,
	output logic             wr_o,
	output logic             busy_o,
	output logic             done_o,
	output logic      [15:0] pc_o,
	output logic      [15:0] sp_o,
	output logic      [15:0] ix_o,
	output logic      [7:0]  acc_a_o,
	output logic      [7:0]  acc_b_o,
	output logic      [7:0]  cc_o
);
	typedef struct packed {
		sfs_pkg::sfs_mode_t mode;
		logic [3:0]  step;
		logic [15:0] addr;
		logic [7:0]  wdata;
		logic        rd;
		logic        wr;
		logic        done;
		logic [15:0] pc;
		logic [15:0] sp;
		logic [15:0] ix;
		logic [7:0]  a;
		logic [7:0]  b;
		logic [7:0]  cc;
		logic [7:0]  lat_hi;
		logic        busy;
	} sfs_state_t;

	sfs_state_t st;
	sfs_state_t next_st;
	logic [15:0] rom_off;
	logic        rom_wr;
	logic [3:0]  look_step;
	logic        look_trap;

	// Table is registered and feeds the cycle after next, so look two steps ahead
	sfs_step_rom u_rom (
		.clk_sys_i (clk_sys_i),
		.rst_n_i   (rst_n_i),
		.trap_i    (look_trap),
		.step_i    (look_step),
		.off_o     (rom_off),
		.wr_o      (rom_wr)
	);

	function automatic logic [7:0] pick_wdata(input logic [3:0] s, input sfs_state_t q);
		case (s)
			4'h3:    pick_wdata = q.pc[7:0];
			4'h4:    pick_wdata = q.pc[15:8];
			4'h5:    pick_wdata = q.ix[7:0];
			4'h6:    pick_wdata = q.ix[15:8];
			4'h7:    pick_wdata = q.a;
			4'h8:    pick_wdata = q.b;
			4'h9:    pick_wdata = q.cc;
			default: pick_wdata = 8'h00;
		endcase
	endfunction

	//------------------------------------------------------------
	// Sequencing
	//------------------------------------------------------------
	always_comb begin
		next_st      = st;
		next_st.done = 1'b0;
		look_trap    = (st.mode == sfs_pkg::SFS_TRAP);
		look_step    = st.step + 4'h2;
		if (st.mode == sfs_pkg::SFS_IDLE) begin
			look_trap = start_trap_i;
			look_step = 4'h2;
		end
		// Read data from the current bus cycle
		if (st.rd && st.mode == sfs_pkg::SFS_RTI) begin
			case (st.step)
				// [RL1] Condition codes
				4'h4: next_st.cc = rdata_i;
				// [RL2] Accumulators B then A
				4'h5: next_st.b = rdata_i;
				4'h6: next_st.a = rdata_i;
				// [RL3] Index high then low
				4'h7: next_st.ix[15:8] = rdata_i;
				4'h8: next_st.ix[7:0] = rdata_i;
				// [RL4] Return address
				4'h9: next_st.lat_hi = rdata_i;
				4'hA: next_st.pc = {st.lat_hi, rdata_i};
				default: next_st.lat_hi = st.lat_hi;
			endcase
		end
		if (st.rd && st.mode == sfs_pkg::SFS_TRAP) begin
			// [RL8] Vector high then low
			if (st.step == 4'hB) begin
				next_st.lat_hi = rdata_i;
			end else if (st.step == sfs_pkg::TRAP_CYCLES) begin
				next_st.pc = {st.lat_hi, rdata_i};
			end
		end
		case (st.mode)
			sfs_pkg::SFS_IDLE: begin
				next_st.rd = 1'b0;
				next_st.wr = 1'b0;
				if (start_trap_i || start_rti_i) begin
					next_st.mode  = start_trap_i ? sfs_pkg::SFS_TRAP : sfs_pkg::SFS_RTI;
					next_st.step  = 4'h1;
					next_st.pc    = pc_i;
					next_st.sp    = sp_i;
					next_st.ix    = ix_i;
					next_st.a     = acc_a_i;
					next_st.b     = acc_b_i;
					next_st.cc    = cc_i;
					next_st.addr  = pc_i;
					next_st.rd    = 1'b1;
				end
			end
			sfs_pkg::SFS_RTI, sfs_pkg::SFS_TRAP: begin
				if ((st.mode == sfs_pkg::SFS_RTI && st.step == sfs_pkg::RTI_CYCLES) ||
					(st.mode == sfs_pkg::SFS_TRAP && st.step == sfs_pkg::TRAP_CYCLES)) begin
					next_st.mode = sfs_pkg::SFS_IDLE;
					next_st.step = 4'h0;
					next_st.rd   = 1'b0;
					next_st.wr   = 1'b0;
					next_st.done = 1'b1;
					if (st.mode == sfs_pkg::SFS_TRAP) begin
						// [RL9] Mask, stack drop
						next_st.cc[sfs_pkg::CC_MASK_BIT] = 1'b1;
						next_st.sp = st.sp - sfs_pkg::FRAME_SIZE;
					end else begin
						next_st.sp = st.sp + sfs_pkg::FRAME_SIZE;
					end
				end else begin
					next_st.step = st.step + 4'h1;
					next_st.wr   = rom_wr;
					next_st.rd   = !rom_wr;
					// [RL5] Opcode, dummy, then stack slots
					if (st.step == 4'h1) begin
						next_st.addr = st.pc + 16'h0001;
					end else if (st.mode == sfs_pkg::SFS_TRAP && st.step == 4'hA) begin
						next_st.addr = sfs_pkg::VEC_TRAP_ADDR;
					end else if (st.mode == sfs_pkg::SFS_TRAP && st.step == 4'hB) begin
						next_st.addr = sfs_pkg::VEC_TRAP_ADDR + 16'h0001;
					end else begin
						next_st.addr = st.sp + rom_off;
					end
					// [RL6] [RL7] Frame bytes pushed
					next_st.wdata = (st.mode == sfs_pkg::SFS_TRAP) ? pick_wdata(st.step + 4'h1, st) : 8'h00;
					if (st.mode == sfs_pkg::SFS_TRAP && st.step == 4'h1) begin
						next_st.pc = st.pc + 16'h0001;
					end
				end
			end
			default: next_st.mode = sfs_pkg::SFS_IDLE;
		endcase
		// Busy kept in a flop so the output has no decode behind it
		next_st.busy = (next_st.mode != sfs_pkg::SFS_IDLE);
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st <= '{mode: sfs_pkg::SFS_IDLE, sp: sfs_pkg::SP_RST, default: '0};
		end else begin
			st <= next_st;
		end
	end

	assign addr_o  = st.addr;
	assign wdata_o = st.wdata;
	assign rd_o    = st.rd;
	assign wr_o    = st.wr;
	assign busy_o  = st.busy;
	assign done_o  = st.done;
	assign pc_o    = st.pc;
	assign sp_o    = st.sp;
	assign ix_o    = st.ix;
	assign acc_a_o = st.a;
	assign acc_b_o = st.b;
	assign cc_o    = st.cc;

	//------------------------------------------------------------
	// Checks
	//------------------------------------------------------------
	a_rti_cc_addr: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // [RL1]
		(st.mode == sfs_pkg::SFS_RTI && st.step == 4'h4) |-> (rd_o && addr_o == st.sp + 16'h0001))
		else $error("restore cc address wrong");
	a_rti_acc_order: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // [RL2]
		(st.mode == sfs_pkg::SFS_RTI && st.step == 4'h5) |-> (addr_o == st.sp + 16'h0002) ##1
		(addr_o == st.sp + 16'h0003 && rd_o))
		else $error("restore accumulator order wrong");
	a_rti_ix_pair: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // [RL3]
		(st.mode == sfs_pkg::SFS_RTI && st.step == 4'h7) |-> (addr_o == st.sp + 16'h0004) ##1
		(addr_o == st.sp + 16'h0005))
		else $error("restore index addresses wrong");
	a_rti_pc_load: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // [RL4]
		(st.mode == sfs_pkg::SFS_RTI && st.step == 4'hA) |=> (pc_o == {$past(st.lat_hi), $past(rdata_i)}))
		else $error("restore pc not loaded");
	a_trap_length: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // [RL5]
		(!busy_o && start_trap_i) |=> busy_o ##11 (busy_o && st.step == 4'hC) ##1 (done_o && !busy_o))
		else $error("trap length not 12");
	a_trap_pc_push: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // [RL5]
		(st.mode == sfs_pkg::SFS_TRAP && st.step == 4'h3) |-> (wr_o && addr_o == st.sp) ##1
		(wr_o && addr_o == st.sp - 16'h0001 && wdata_o == st.pc[15:8]))
		else $error("trap pc push wrong");
	a_trap_ix_push: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // [RL6]
		(st.mode == sfs_pkg::SFS_TRAP && st.step == 4'h5) |-> (wr_o && wdata_o == st.ix[7:0] &&
		addr_o == st.sp - 16'h0002))
		else $error("trap index push wrong");
	a_trap_cc_push: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // [RL7]
		(st.mode == sfs_pkg::SFS_TRAP && st.step == 4'h9) |-> (wr_o && wdata_o == st.cc &&
		addr_o == st.sp - 16'h0006))
		else $error("trap cc push wrong");
	a_trap_vector: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // [RL8]
		(st.mode == sfs_pkg::SFS_TRAP && st.step == 4'hA) |-> (rd_o && addr_o == st.sp - 16'h0007) ##1
		(addr_o == sfs_pkg::VEC_TRAP_ADDR) ##1 (addr_o == sfs_pkg::VEC_TRAP_ADDR + 16'h0001))
		else $error("trap vector fetch wrong");
	a_trap_finish: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // [RL9]
		(st.mode == sfs_pkg::SFS_TRAP && st.step == 4'hC) |=> (cc_o[sfs_pkg::CC_MASK_BIT] &&
		sp_o == $past(st.sp) - sfs_pkg::FRAME_SIZE))
		else $error("trap finish state wrong");
endmodule
`default_nettype wire

// *** verif/sfs_mem_model.sv ***
// Purpose: behavioural memory on the far side of the sequencer bus
// Assumes: reads answered in the same cycle, writes taken at the edge
// Notes:   an idle data line shows the inverted last value, never a hold
`timescale 1ns/1ps
`default_nettype none
module sfs_mem_model (
	input  wire logic        clk_sys_i,
	input  wire logic [15:0] addr_i,
	input  wire logic [7:0]  wdata_i,
	input  wire logic        rd_i,
	input  wire logic        wr_i,
	output logic      [7:0]  rdata_o
);
	logic [7:0] mem [0:65535];
	logic [7:0] last = 8'h00;

	// Stale data would hide a read taken in the wrong cycle
	always_comb rdata_o = rd_i ? mem[addr_i] : ~last;

	always @(posedge clk_sys_i) begin
		if (wr_i) mem[addr_i] <= wdata_i;
		if (rd_i) last <= mem[addr_i];
	end
endmodule
`default_nettype wire

// *** verif/stack_frame_sequencer_tb.sv ***
// Purpose: self-checking bench for the stack frame sequencer
// Assumes: bus cycle k is visible just after the k-th edge past the start
// Notes:   each trap is followed at once by a restore of the saved frame
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp, msg) begin samples_checked++; if ((got) !== (exp)) begin \
	n_fail++; $display("unexpected at %0t: %s", $time, msg); end end
module stack_frame_sequencer_tb;
	logic        clk_sys_i = 1'b0;
	logic        rst_n_i = 1'b0;
	logic        start_rti_i = 1'b0;
	logic        start_trap_i = 1'b0;
	logic [15:0] pc_i = 16'h0000, sp_i = 16'h0000, ix_i = 16'h0000;
	logic [7:0]  acc_a_i = 8'h00, acc_b_i = 8'h00, cc_i = 8'h00;
	logic [7:0]  rdata, wdata, acc_a_o, acc_b_o, cc_o, f_a, f_b, f_cc;
	logic [15:0] addr, pc_o, sp_o, ix_o, f_pc, f_ix;
	logic        rd_o, wr_o, busy_o, done_o;
	int          n_fail = 0;
	int          samples_checked = 0;

	sfs_top u_dut (.clk_sys_i, .rst_n_i, .start_rti_i, .start_trap_i, .pc_i, .sp_i, .ix_i,
		.acc_a_i, .acc_b_i, .cc_i, .rdata_i(rdata), .addr_o(addr), .wdata_o(wdata), .rd_o,
		.wr_o, .busy_o, .done_o, .pc_o, .sp_o, .ix_o, .acc_a_o, .acc_b_o, .cc_o);
	sfs_mem_model u_mem (.clk_sys_i, .addr_i(addr), .wdata_i(wdata), .rd_i(rd_o),
		.wr_i(wr_o), .rdata_o(rdata));

	initial forever #50 clk_sys_i = ~clk_sys_i;

	task automatic summarize;
		$display("checked %0d, failed %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask

	// Walks one sequence; poke adds start_rti_i at start and raises both starts mid-run
	task automatic run(input logic trap, input logic poke, input logic [15:0] pc, sp, ix,
		input logic [7:0] a, b, cc);
		logic [15:0] ea, pr;
		logic [55:0] wv;
		logic        wx;
		int          n;
		logic [72:0] ev;
		pr = pc + 16'h0001;
		wv = {cc, b, a, ix, pr};
		n = trap ? 12 : 10;
		{start_trap_i, start_rti_i} = {trap, !trap | poke};
		{pc_i, sp_i, ix_i, acc_a_i, acc_b_i, cc_i} = {pc, sp, ix, a, b, cc};
		if (trap) {f_pc, f_ix, f_a, f_b, f_cc} = {pr, ix, a, b, cc};
		for (int k = 1; k <= n + 1; k++) begin
			@(posedge clk_sys_i);
			#10;
			if (k == 1 || k == 6) {start_trap_i, start_rti_i} = 2'b00;
			if (poke && k == 5) {start_trap_i, start_rti_i} = 2'b11;
			if (k <= n) begin
				ea = (k == 1) ? pc : (k == 2) ? pr : !trap ? sp + 16'(k - 3) :
					(k > 10) ? sfs_pkg::VEC_TRAP_ADDR + 16'(k - 11) : sp - 16'(k - 3);
				wx = trap && k >= 3 && k <= 9;
				`CHK(addr, ea, "bus address")
				`CHK({rd_o, wr_o, busy_o}, {!wx, wx, 1'b1}, "bus strobes")
				if (wx) `CHK(wdata, wv[8*(k-3) +: 8], "write data")
			end else begin
				// Trap lands on the vector in memory, restore on the saved frame
				ev = trap ? {1'b1, 16'h5AC3, sp - sfs_pkg::FRAME_SIZE, ix, a, b,
					cc | 8'(1 << sfs_pkg::CC_MASK_BIT)} :
					{1'b1, f_pc, sp + sfs_pkg::FRAME_SIZE, f_ix, f_a, f_b, f_cc};
				`CHK({done_o, pc_o, sp_o, ix_o, acc_a_o, acc_b_o, cc_o}, ev, "final registers")
			end
		end
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic trap_then_restore;
		run(1'b1, 1'b0, 16'h1000, 16'h01FF, 16'hA55A, 8'h11, 8'h22, 8'h83);
		run(1'b0, 1'b1, 16'hEEEE, 16'h01F8, 16'h0F0F, 8'hEE, 8'hDD, 8'h7C);
	endtask

	// Address wrap at both ends, trap chosen over restore
	task automatic wrap_and_priority;
		run(1'b1, 1'b1, 16'hFFFF, 16'h0003, 16'h1234, 8'h9C, 8'h3F, 8'hC0);
		run(1'b0, 1'b0, 16'h4321, 16'hFFFC, 16'hEDCB, 8'h63, 8'hC0, 8'h3F);
	endtask

	initial begin
		u_mem.mem[sfs_pkg::VEC_TRAP_ADDR] = 8'h5A;
		u_mem.mem[sfs_pkg::VEC_TRAP_ADDR + 16'h0001] = 8'hC3;
		repeat (2) @(posedge clk_sys_i);
		#10;
		rst_n_i = 1'b1;
		trap_then_restore();
		wrap_and_priority();
		summarize();
	end
endmodule
`default_nettype wire
